// ==== channel_filter_config_regs.sv ====
// Per-channel filter configuration registers for channels one to four
`timescale 1ns/1ps
// Notes on behaviour
// - Bit 14 enables channel high-pass stage
// - Bits 13:10 set high-pass corner
// - Bits 9:7 choose filter response
// - Bits 6:4 set decimation factor
// - Bit 2 selects odd-tap coefficients
// - Bit 0 routes samples through filter
// - Four identical registers at 2Eh..31h
// - Global gate qualifies all channel filtering
module channel_filter_config_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic global_filter_gate,
  output logic [3:0] highpass_on,
  output logic [15:0] highpass_corner,
  output logic [11:0] response_select,
  output logic [11:0] downsample_factor,
  output logic [3:0] odd_coeff_count,
  output logic [3:0] filter_on
);
  // Whole module state
  typedef struct packed {
    logic [3:0][15:0] cfg;
    logic gate;
    logic [15:0] rdata;
    logic [3:0] hp;
    logic [15:0] corner;
    logic [11:0] resp;
    logic [11:0] dsf;
    logic [3:0] odd;
    logic [3:0] filt;
  } state_s;

  state_s st_q;
  state_s st_d;
  // Decoder outputs
  logic [3:0] chan_hit;
  logic glob_hit;
  // Field views of the next register values
  logic [3:0] hp_w;
  logic [3:0][3:0] corner_w;
  logic [3:0][2:0] resp_w;
  logic [3:0][2:0] dsf_w;
  logic [3:0] odd_w;
  logic [3:0] filt_w;

  // Register selection
  chan_addr_dec u_dec (
    .addr(addr),
    .chan_hit(chan_hit),
    .glob_hit(glob_hit)
  );

  // One field splitter per channel, fed from next state so outputs stay registered
  for (genvar i = 0; i < chan_filt_pkg::NUM_CHAN; i++) begin : g_split
    chan_field_split u_split (
      .cfg(st_d.cfg[i]),
      .gate(st_d.gate),
      .hp_on(hp_w[i]),
      .corner(corner_w[i]),
      .resp(resp_w[i]),
      .dsf(dsf_w[i]),
      .odd(odd_w[i]),
      .filt_on(filt_w[i])
    );
  end

  // Next-state logic: writes, read mux, field outputs
  always_comb begin
    st_d = st_q;
    // Reserved bits are dropped, so a careless write cannot set them
    for (int i = 0; i < chan_filt_pkg::NUM_CHAN; i++) begin
      if (wr && chan_hit[i]) begin
        st_d.cfg[i] = wdata & chan_filt_pkg::CFG_MASK;
      end
    end
    if (wr && glob_hit) begin
      st_d.gate = wdata[chan_filt_pkg::GATE_BIT];
    end
    // Read data valid only in the cycle after the strobe; unmapped reads zero
    st_d.rdata = 16'h0000;
    if (rd) begin
      for (int i = 0; i < chan_filt_pkg::NUM_CHAN; i++) begin
        if (chan_hit[i]) begin
          st_d.rdata = st_q.cfg[i];
        end
      end
      if (glob_hit) begin
        st_d.rdata = {14'h0, st_q.gate, 1'b0};
      end
    end
    st_d.hp = hp_w;
    st_d.corner = corner_w;
    st_d.resp = resp_w;
    st_d.dsf = dsf_w;
    st_d.odd = odd_w;
    st_d.filt = filt_w;
  end

  // State register; everything clears to disabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign rdata = st_q.rdata;
  assign global_filter_gate = st_q.gate;
  assign highpass_on = st_q.hp;
  assign highpass_corner = st_q.corner;
  assign response_select = st_q.resp;
  assign downsample_factor = st_q.dsf;
  assign odd_coeff_count = st_q.odd;
  assign filter_on = st_q.filt;

  // High-pass enable bit of channel one shows the cycle after its write, gated
  a_hp_enable: assert property (@(posedge clk) disable iff (rst)
    wr && chan_hit[0] |=> highpass_on[0] == ($past(wdata[14]) && global_filter_gate))
    else $error("high-pass enable mismatch");
  a_corner_field: assert property (@(posedge clk) disable iff (rst)
    wr && chan_hit[1] |=> highpass_corner[7:4] == $past(wdata[13:10]))
    else $error("corner field mismatch");
  a_resp_field: assert property (@(posedge clk) disable iff (rst)
    wr && chan_hit[2] |=> response_select[8:6] == $past(wdata[9:7]))
    else $error("response field mismatch");
  a_dsf_field: assert property (@(posedge clk) disable iff (rst)
    wr && chan_hit[3] |=> downsample_factor[11:9] == $past(wdata[6:4]))
    else $error("decimation field mismatch");
  a_odd_field: assert property (@(posedge clk) disable iff (rst)
    wr && chan_hit[0] |=> odd_coeff_count[0] == $past(wdata[2]))
    else $error("odd tap field mismatch");
  a_filter_gate: assert property (@(posedge clk) disable iff (rst)
    !global_filter_gate |-> filter_on == 4'h0 && highpass_on == 4'h0)
    else $error("filter active without global gate");
  a_read_back: assert property (@(posedge clk) disable iff (rst)
    wr && addr == 8'h30 ##1 rd && addr == 8'h30 |=> rdata == ($past(wdata, 2) & 16'h7FF5))
    else $error("readback mismatch");
  a_gate_write: assert property (@(posedge clk) disable iff (rst)
    wr && glob_hit |=> global_filter_gate == $past(wdata[1]))
    else $error("global gate write mismatch");
  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    $past(rd) && !$past(glob_hit) |-> (rdata & 16'h800A) == 16'h0000)
    else $error("reserved bit read as one");
  // Filter enable of channel three follows its write, gated by the global bit
  a_filter_enable: assert property (@(posedge clk) disable iff (rst)
    wr && chan_hit[2] |=> filter_on[2] == ($past(wdata[0]) && global_filter_gate))
    else $error("filter enable mismatch");
  // Read data bus stays quiet unless a read was taken the edge before
  a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    !rd |=> rdata == 16'h0000)
    else $error("read data without read strobe");
  // Writes outside the channel block leave every channel word alone
  a_unmapped_write: assert property (@(posedge clk) disable iff (rst)
    wr && chan_hit == 4'h0 |=> $stable(st_q.cfg))
    else $error("channel word changed by foreign write");
endmodule : channel_filter_config_regs

// ==== chan_filt_pkg.sv ====
// Shared constants for the per-channel filter configuration block
package chan_filt_pkg;
  // Register indices and widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_CHAN = 4;
  localparam logic [7:0] CHAN1_FILTER_CFG = 8'h2E;
  localparam logic [7:0] CHAN2_FILTER_CFG = 8'h2F;
  localparam logic [7:0] CHAN3_FILTER_CFG = 8'h30;
  localparam logic [7:0] CHAN4_FILTER_CFG = 8'h31;
  // Global gate register and its bit
  localparam logic [7:0] GLOBAL_CTRL = 8'h29;
  localparam int GATE_BIT = 1;
  // Field positions
  localparam int HP_ON_BIT = 14;
  localparam int CORNER_LSB = 10;
  localparam int RESP_LSB = 7;
  localparam int DSF_LSB = 4;
  localparam int ODD_BIT = 2;
  localparam int FILT_BIT = 0;
  // Writable bits; 15, 3 and 1 are reserved and read zero
  localparam logic [15:0] CFG_MASK = 16'h7FF5;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] GLOBAL_MASK = 16'h0002;
endpackage : chan_filt_pkg

// ==== chan_field_split.sv ====
// Splits one stored channel word into its filter fields
`timescale 1ns/1ps
module chan_field_split (
  input wire logic [15:0] cfg,
  input wire logic gate,
  output logic hp_on,
  output logic [3:0] corner,
  output logic [2:0] resp,
  output logic [2:0] dsf,
  output logic odd,
  output logic filt_on
);
  // Fields decoded; enables only live while the global gate is set
  always_comb begin
    hp_on = gate & cfg[chan_filt_pkg::HP_ON_BIT];
    corner = cfg[chan_filt_pkg::CORNER_LSB +: 4];
    resp = cfg[chan_filt_pkg::RESP_LSB +: 3];
    dsf = cfg[chan_filt_pkg::DSF_LSB +: 3];
    odd = cfg[chan_filt_pkg::ODD_BIT];
    filt_on = gate & cfg[chan_filt_pkg::FILT_BIT];
  end
endmodule : chan_field_split

// ==== chan_addr_dec.sv ====
// Address decode for the four channel registers and the global control
`timescale 1ns/1ps
module chan_addr_dec (
  input wire logic [7:0] addr,
  output logic [3:0] chan_hit,
  output logic glob_hit
);
  // One-hot per channel, consecutive indices from channel 1
  always_comb begin
    chan_hit = 4'h0;
    if (addr >= chan_filt_pkg::CHAN1_FILTER_CFG && addr <= chan_filt_pkg::CHAN4_FILTER_CFG) begin
      chan_hit[2'(addr - chan_filt_pkg::CHAN1_FILTER_CFG)] = 1'b1;
    end
    glob_hit = (addr == chan_filt_pkg::GLOBAL_CTRL);
  end
endmodule : chan_addr_dec

// ==== testbench.sv ====
// Self-checking bench for the channel filter configuration registers
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0; // 200 MHz clock
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0; // Read taken at the last edge
  logic [15:0] rdata, highpass_corner;
  logic global_filter_gate;
  logic [3:0] highpass_on, odd_coeff_count, filter_on;
  logic [11:0] response_select, downsample_factor;
  logic [15:0] m [4]; // Reference copy of the channel words
  logic g; // Reference global gate
  logic [15:0] exp_q [$]; // Expected read data, oldest first
  int mismatches = 0;
  int checked = 0;
  channel_filter_config_regs u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .global_filter_gate(global_filter_gate), .highpass_on(highpass_on),
    .highpass_corner(highpass_corner), .response_select(response_select),
    .downsample_factor(downsample_factor), .odd_coeff_count(odd_coeff_count), .filter_on(filter_on));
  // Free-running clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // One-cycle write; reference follows the write at once
  task automatic wr_t(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    if (a >= 8'h2E && a <= 8'h31) m[a - 8'h2E] = d & chan_filt_pkg::CFG_MASK;
    if (a == chan_filt_pkg::GLOBAL_CTRL) g = d[1];
  endtask : wr_t
  // One-cycle read; expected data noted for the watcher
  task automatic rd_t(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    if (a >= 8'h2E && a <= 8'h31) exp_q.push_back(m[a - 8'h2E]);
    else exp_q.push_back((a == 8'h29) ? {14'h0, g, 1'b0} : 16'h0000);
  endtask : rd_t
  // Bus idle, then every field output against the reference
  task automatic idle_chk();
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk);
    cmp("global_filter_gate", 16'(global_filter_gate), 16'(g));
    for (int i = 0; i < 4; i++) begin
      cmp("highpass_on", 16'(highpass_on[i]), 16'(m[i][14] & g));
      cmp("highpass_corner", 16'(highpass_corner[4*i+:4]), 16'(m[i][13:10]));
      cmp("response_select", 16'(response_select[3*i+:3]), 16'(m[i][9:7]));
      cmp("downsample_factor", 16'(downsample_factor[3*i+:3]), 16'(m[i][6:4]));
      cmp("odd_coeff_count", 16'(odd_coeff_count[i]), 16'(m[i][2]));
      cmp("filter_on", 16'(filter_on[i]), 16'(m[i][0] & g));
    end
  endtask : idle_chk
  // Read data stand only in the cycle after the strobe
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) begin
    if (rd_q && exp_q.size() > 0) cmp("rdata", exp_q.pop_front(), rdata);
    else cmp("rdata_idle", rdata, 16'h0000);
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
  // Main sequence: reset values, random rounds, mid-run reset
  initial begin
    logic [15:0] d;
    g = 1'b0;
    foreach (m[i]) m[i] = 16'h0000;
    void'($urandom(32'hE2BC));
    for (int r = 0; r < 8; r++) begin
      if (r == 0 || r == 7) begin
        // Mid-run reset is raised on a rising edge like every other input
        if (r != 0) @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        g = 1'b0;
        foreach (m[i]) m[i] = 16'h0000;
        rst <= 1'b0;
      end else begin
        // Back-to-back writes; first round sets reserved bits too
        for (int i = 0; i < 4; i++) begin
          // Round one sets reserved bits on purpose; later rounds keep them zero
          d = (r == 1) ? 16'hFFFF : 16'($urandom) & chan_filt_pkg::CFG_MASK;
          wr_t(8'h2E + 8'(i), d);
        end
        // Write then read back at once on channel three
        d = 16'($urandom) & chan_filt_pkg::CFG_MASK;
        wr_t(chan_filt_pkg::CHAN3_FILTER_CFG, d);
        rd_t(chan_filt_pkg::CHAN3_FILTER_CFG);
        d = 16'($urandom);
        wr_t(chan_filt_pkg::GLOBAL_CTRL, {d[15:2], r[0], d[0]});
        wr_t(8'h2D, 16'($urandom));
        wr_t(8'h32, 16'($urandom));
      end
      idle_chk();
      for (logic [7:0] a = 8'h28; a <= 8'h33; a++) rd_t(a);
      idle_chk();
      $display("test round %0d done", r);
    end
    conclude();
  end
endmodule : testbench
